// file: logic/vf_sep_stall_ctrl.v
// Top of the V/F separation and stall control: APB registers, voltage source
// selection, voltage and frequency ramps, shutdown sequencing, stall limits.
// Assumes synchronous inputs on clk and a single-master APB.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "vf_sep_defines.vh"
module vf_sep_stall_ctrl #(
  parameter SAMPLE_CYCLES = 1000000,
  parameter RATED_VOLT = 16'h0DAC,
  parameter RATED_FREQ = 16'h1388
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] analogInputOne,
  input wire [15:0] analogInputTwo,
  input wire [15:0] analogInputThree,
  input wire [15:0] sequencerValue,
  input wire [15:0] pidValue,
  input wire [15:0] hostValue,
  input wire [15:0] targetFreq,
  input wire [15:0] outputCurrent,
  input wire [15:0] busVoltage,
  output reg [15:0] outVoltage,
  output reg [15:0] outFreq,
  output reg ocStallActive,
  output reg ovStallActive,
  output reg stopped
);
  localparam SAMPLES_PER_TENTH = 100000 / (`SAMPLE_TIME_US / 1000) / 1000;
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_VOLT_DOWN = 2'b10;
  localparam ST_FREQ_DOWN = 2'b11;

  reg [3:0] voltageSourceSelect;
  reg [15:0] digitalVoltageSetpoint;
  reg [15:0] voltageRiseTime;
  reg [15:0] voltageDropTime;
  reg separationShutdownMode;
  reg [15:0] frequencyDecelTime;
  reg [7:0] overcurrentStallThreshold;
  reg overcurrentStallSwitch;
  reg [7:0] overcurrentStallGain;
  reg [7:0] highspeedLimitFactor;
  reg [15:0] overvoltageStallPoint;
  reg overvoltageStallSwitch;
  reg [7:0] overvoltageFreqGain;
  reg [7:0] overvoltageVoltGain;
  reg [15:0] overvoltageMaxFreqRise;
  reg [7:0] overexcitationGain;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] sampleCount;
  reg tick;
  reg [15:0] srcPct;
  reg [15:0] srcMag;
  reg [31:0] scaled;
  reg [15:0] voltTarget;
  reg [15:0] freqTarget;
  reg [31:0] limitWide;
  reg [15:0] limitCur;
  reg [15:0] freqCorr;
  reg [15:0] next_freqCorr;
  reg [15:0] ovCorr;
  reg [15:0] next_ovCorr;
  reg [15:0] prevBus;
  reg [31:0] ovTerm;
  reg [31:0] ocTerm;
  reg [16:0] freqSum;
  reg runCmd;
  reg stopCmd;
  wire [15:0] rampVolt;
  wire [15:0] rampFreq;
  wire voltDone;
  wire apbWrite;
  wire ocOver;
  wire ovOver;

  assign apbWrite = psel & penable & pwrite;
  assign ocOver = overcurrentStallSwitch == 1'b0 &&
    outputCurrent > limitCur;
  assign ovOver = overvoltageStallSwitch == 1'b1 &&
    busVoltage > overvoltageStallPoint;

  // APB register writes, one-cycle run and stop strobes
  always @(posedge clk) begin
    if (rst) begin
      voltageSourceSelect <= `RST_VOLT_SOURCE;
      digitalVoltageSetpoint <= `RST_DIGITAL_VOLT;
      voltageRiseTime <= `RST_RISE_TIME;
      voltageDropTime <= `RST_DROP_TIME;
      separationShutdownMode <= 1'b0;
      frequencyDecelTime <= `RST_DECEL_TIME;
      overcurrentStallThreshold <= `RST_OC_THRESHOLD;
      overcurrentStallSwitch <= `RST_OC_SWITCH;
      overcurrentStallGain <= `RST_OC_GAIN;
      highspeedLimitFactor <= `RST_HS_FACTOR;
      overvoltageStallPoint <= `RST_OV_POINT;
      overvoltageStallSwitch <= `RST_OV_SWITCH;
      overvoltageFreqGain <= `RST_OV_FREQ_GAIN;
      overvoltageVoltGain <= `RST_OV_VOLT_GAIN;
      overvoltageMaxFreqRise <= `RST_OV_MAX_RISE;
      overexcitationGain <= `RST_OVEREXC_GAIN;
      runCmd <= 1'b0;
      stopCmd <= 1'b0;
    end else begin
      runCmd <= 1'b0;
      stopCmd <= 1'b0;
      if (apbWrite) begin
        case (paddr)
          `ADDR_VOLT_SOURCE: if (pwdata[3:0] <= `SRC_HOST)
            voltageSourceSelect <= pwdata[3:0];
          `ADDR_DIGITAL_VOLT: if (pwdata[15:0] <= 16'h2710)
            digitalVoltageSetpoint <= pwdata[15:0];
          `ADDR_RISE_TIME: if (pwdata[15:0] <= `RAMP_TIME_MAX)
            voltageRiseTime <= pwdata[15:0];
          `ADDR_DROP_TIME: if (pwdata[15:0] <= `RAMP_TIME_MAX)
            voltageDropTime <= pwdata[15:0];
          `ADDR_SHUTDOWN_MODE: separationShutdownMode <= pwdata[0];
          `ADDR_DECEL_TIME: if (pwdata[15:0] <= `RAMP_TIME_MAX)
            frequencyDecelTime <= pwdata[15:0];
          `ADDR_OC_THRESHOLD:
            if (pwdata[7:0] >= 8'h32 && pwdata[7:0] <= 8'hC8)
              overcurrentStallThreshold <= pwdata[7:0];
          `ADDR_OC_SWITCH: overcurrentStallSwitch <= pwdata[0];
          `ADDR_OC_GAIN: if (pwdata[7:0] <= 8'h64)
            overcurrentStallGain <= pwdata[7:0];
          `ADDR_HS_FACTOR:
            if (pwdata[7:0] >= 8'h32 && pwdata[7:0] <= 8'hC8)
              highspeedLimitFactor <= pwdata[7:0];
          `ADDR_OV_POINT:
            if (pwdata[15:0] >= 16'h1770 && pwdata[15:0] <= 16'h1F40)
              overvoltageStallPoint <= pwdata[15:0];
          `ADDR_OV_SWITCH: overvoltageStallSwitch <= pwdata[0];
          `ADDR_OV_FREQ_GAIN: if (pwdata[7:0] <= 8'hC8)
            overvoltageFreqGain <= pwdata[7:0];
          `ADDR_OV_VOLT_GAIN: if (pwdata[7:0] <= 8'h64)
            overvoltageVoltGain <= pwdata[7:0];
          `ADDR_OV_MAX_RISE: if (pwdata[15:0] <= 16'h1388)
            overvoltageMaxFreqRise <= pwdata[15:0];
          `ADDR_OVEREXC_GAIN: if (pwdata[7:0] <= 8'hC8)
            overexcitationGain <= pwdata[7:0];
          `ADDR_CONTROL: begin
            runCmd <= pwdata[`CONTROL_RUN_BIT];
            stopCmd <= pwdata[`CONTROL_STOP_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // APB answer: no wait state, read data registered, unmapped errors
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `ADDR_VOLT_SOURCE: prdata[3:0] <= voltageSourceSelect;
          `ADDR_DIGITAL_VOLT: prdata[15:0] <= digitalVoltageSetpoint;
          `ADDR_RISE_TIME: prdata[15:0] <= voltageRiseTime;
          `ADDR_DROP_TIME: prdata[15:0] <= voltageDropTime;
          `ADDR_SHUTDOWN_MODE: prdata[0] <= separationShutdownMode;
          `ADDR_DECEL_TIME: prdata[15:0] <= frequencyDecelTime;
          `ADDR_OC_THRESHOLD: prdata[7:0] <= overcurrentStallThreshold;
          `ADDR_OC_SWITCH: prdata[0] <= overcurrentStallSwitch;
          `ADDR_OC_GAIN: prdata[7:0] <= overcurrentStallGain;
          `ADDR_HS_FACTOR: prdata[7:0] <= highspeedLimitFactor;
          `ADDR_OV_POINT: prdata[15:0] <= overvoltageStallPoint;
          `ADDR_OV_SWITCH: prdata[0] <= overvoltageStallSwitch;
          `ADDR_OV_FREQ_GAIN: prdata[7:0] <= overvoltageFreqGain;
          `ADDR_OV_VOLT_GAIN: prdata[7:0] <= overvoltageVoltGain;
          `ADDR_OV_MAX_RISE: prdata[15:0] <= overvoltageMaxFreqRise;
          `ADDR_OVEREXC_GAIN: prdata[7:0] <= overexcitationGain;
          `ADDR_CONTROL: prdata[1:0] <= 2'b00;
          `ADDR_STATUS: prdata[4:0] <= {stopped, ovStallActive,
            ocStallActive, state};
          `ADDR_OUT_VOLT: prdata[15:0] <= outVoltage;
          `ADDR_OUT_FREQ: prdata[15:0] <= outFreq;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control sample strobe
  always @(posedge clk) begin
    if (rst) begin
      sampleCount <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (sampleCount == SAMPLE_CYCLES - 1);
      sampleCount <= (sampleCount == SAMPLE_CYCLES - 1) ? 32'h0 :
        sampleCount + 32'h1;
    end
  end

  // Voltage source selection and scaling to rated voltage
  always @* begin
    case (voltageSourceSelect)
      `SRC_AI_ONE: srcPct = analogInputOne;
      `SRC_AI_TWO: srcPct = analogInputTwo;
      `SRC_AI_THREE: srcPct = analogInputThree;
      `SRC_SEQUENCER: srcPct = sequencerValue;
      `SRC_PID: srcPct = pidValue;
      `SRC_HOST: srcPct = hostValue;
      default: srcPct = 16'h0000;
    endcase
    srcMag = srcPct[15] ? (~srcPct + 16'h1) : srcPct;
    scaled = srcMag * RATED_VOLT / `PCT_FULL;
    if (voltageSourceSelect == `SRC_DIGITAL)
      voltTarget = digitalVoltageSetpoint;
    else
      voltTarget = (scaled > 32'h0000FFFF) ? 16'hFFFF : scaled[15:0];
    if (state == ST_RUN)
      freqTarget = targetFreq;
    else if (state == ST_VOLT_DOWN && separationShutdownMode)
      freqTarget = rampFreq;
    else
      freqTarget = 16'h0000;
    if (state == ST_IDLE || state == ST_VOLT_DOWN ||
        state == ST_FREQ_DOWN)
      voltTarget = 16'h0000;
  end

  // Shutdown sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (runCmd) next_state = ST_RUN;
      ST_RUN: if (stopCmd)
        next_state = separationShutdownMode ? ST_VOLT_DOWN : ST_FREQ_DOWN;
      ST_VOLT_DOWN: if (voltDone && rampVolt == 16'h0)
        next_state = ST_FREQ_DOWN;
      ST_FREQ_DOWN: if (rampVolt == 16'h0 && rampFreq == 16'h0)
        next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ramp_unit #(.W(16), .SAMPLES_PER_TENTH(SAMPLES_PER_TENTH)) voltRamp (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .target(voltTarget),
    .fullScale(RATED_VOLT),
    .upTime(voltageRiseTime),
    .downTime(voltageDropTime),
    .value(rampVolt),
    .atTarget(voltDone)
  );

  ramp_unit #(.W(16), .SAMPLES_PER_TENTH(SAMPLES_PER_TENTH)) freqRamp (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .target(freqTarget),
    .fullScale(RATED_FREQ),
    .upTime(frequencyDecelTime),
    .downTime(frequencyDecelTime),
    .value(rampFreq),
    .atTarget()
  );

  // Stall threshold in current units, rescaled above rated frequency by outFreq and the high-speed factor unless the factor is HS_UNITY
  always @* begin
    if (outFreq > RATED_FREQ && highspeedLimitFactor != `HS_UNITY)
      limitWide = overcurrentStallThreshold * outFreq / RATED_FREQ
        * highspeedLimitFactor / 100;
    else
      limitWide = {24'h0, overcurrentStallThreshold};
    limitCur = (limitWide * 10 > 32'h0000FFFF) ? 16'hFFFF :
      limitWide[15:0] * 16'd10;
    ocTerm = (outputCurrent - limitCur) * overcurrentStallGain / 100;
    ovTerm = (busVoltage - prevBus) * overvoltageVoltGain / 16 +
      (busVoltage - overvoltageStallPoint) * overvoltageFreqGain / 64;
    next_freqCorr = freqCorr;
    next_ovCorr = ovCorr;
    if (ocOver) begin
      next_freqCorr = freqCorr + ocTerm[15:0] + 16'h1;
      next_ovCorr = 16'h0;
    end else begin
      next_freqCorr = (freqCorr > 16'h1) ? freqCorr - 16'h1 : 16'h0;
      if (ovOver)
        next_ovCorr = (ovCorr + ovTerm[15:0] > overvoltageMaxFreqRise) ?
          overvoltageMaxFreqRise : ovCorr + ovTerm[15:0];
      else
        next_ovCorr = (ovCorr > 16'h1) ? ovCorr - 16'h1 : 16'h0;
    end
    freqSum = {1'b0, rampFreq} + {1'b0, ovCorr};
  end

  // Output stage: corrections applied each sample
  always @(posedge clk) begin
    if (rst) begin
      freqCorr <= 16'h0;
      ovCorr <= 16'h0;
      prevBus <= 16'h0;
      outVoltage <= 16'h0;
      outFreq <= 16'h0;
      ocStallActive <= 1'b0;
      ovStallActive <= 1'b0;
      stopped <= 1'b1;
    end else begin
      outVoltage <= rampVolt;
      stopped <= (state == ST_IDLE);
      if (tick) begin
        freqCorr <= next_freqCorr;
        ovCorr <= next_ovCorr;
        prevBus <= busVoltage;
        ocStallActive <= ocOver;
        ovStallActive <= ovOver & ~ocOver;
      end
      if (freqSum[15:0] > freqCorr && !freqSum[16])
        outFreq <= freqSum[15:0] - freqCorr;
      else if (freqSum[16])
        outFreq <= 16'hFFFF;
      else
        outFreq <= 16'h0;
    end
  end
endmodule // vf_sep_stall_ctrl

// file: logic/vf_sep_defines.vh
// Constants, APB register map, reset values and timing of the V/F separation
// and stall control block. Assumes a 100 MHz clock and a 10 ms control sample.
`ifndef VF_SEP_DEFINES_VH
`define VF_SEP_DEFINES_VH

// Register byte addresses
`define ADDR_VOLT_SOURCE 12'h000
`define ADDR_DIGITAL_VOLT 12'h004
`define ADDR_RISE_TIME 12'h008
`define ADDR_DROP_TIME 12'h00C
`define ADDR_SHUTDOWN_MODE 12'h010
`define ADDR_DECEL_TIME 12'h014
`define ADDR_OC_THRESHOLD 12'h018
`define ADDR_OC_SWITCH 12'h01C
`define ADDR_OC_GAIN 12'h020
`define ADDR_HS_FACTOR 12'h024
`define ADDR_OV_POINT 12'h028
`define ADDR_OV_SWITCH 12'h02C
`define ADDR_OV_FREQ_GAIN 12'h030
`define ADDR_OV_VOLT_GAIN 12'h034
`define ADDR_OV_MAX_RISE 12'h038
`define ADDR_CONTROL 12'h03C
`define ADDR_STATUS 12'h040
`define ADDR_OUT_VOLT 12'h044
`define ADDR_OUT_FREQ 12'h048
`define ADDR_OVEREXC_GAIN 12'h04C

// Reset values (times in 0.1 s, voltages in 0.1 V, frequency in 0.01 Hz)
`define RST_VOLT_SOURCE 4'h0
`define RST_DIGITAL_VOLT 16'h0000
`define RST_RISE_TIME 16'h0000
`define RST_DROP_TIME 16'h0000
`define RST_DECEL_TIME 16'h0064
`define RST_OC_THRESHOLD 8'h96
`define RST_OC_SWITCH 1'b1
`define RST_OC_GAIN 8'h14
`define RST_HS_FACTOR 8'h32
`define RST_OV_POINT 16'h1B58
`define RST_OV_SWITCH 1'b1
`define RST_OV_FREQ_GAIN 8'h64
`define RST_OV_VOLT_GAIN 8'h1E
`define RST_OV_MAX_RISE 16'h01F4
`define RST_OVEREXC_GAIN 8'h40

// Voltage source codes
`define SRC_DIGITAL 4'h0
`define SRC_AI_ONE 4'h1
`define SRC_AI_TWO 4'h2
`define SRC_AI_THREE 4'h3
`define SRC_SEQUENCER 4'h6
`define SRC_PID 4'h7
`define SRC_HOST 4'h8

// Fixed points and limits
`define PCT_FULL 16'h03E8
`define HS_UNITY 8'h32
`define RAMP_TIME_MAX 16'h2710
`define SAMPLE_TIME_US 10000
`define CLK_PERIOD_NS 10
`define CONTROL_RUN_BIT 0
`define CONTROL_STOP_BIT 1

`endif

// file: logic/ramp_unit.v
// Linear ramp of one quantity toward a target, stepping once per sample.
// Assumes time given in 0.1 s units and full scale the rated value.
`timescale 1ns/100ps
module ramp_unit #(
  parameter W = 16,
  parameter SAMPLES_PER_TENTH = 10
) (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire [W-1:0] target,
  input wire [W-1:0] fullScale,
  input wire [15:0] upTime,
  input wire [15:0] downTime,
  output reg [W-1:0] value,
  output reg atTarget
);
  reg [W-1:0] stepUp;
  reg [W-1:0] stepDown;
  reg [W-1:0] next_value;
  reg [31:0] samplesUp;
  reg [31:0] samplesDown;
  reg [31:0] quotUp;
  reg [31:0] quotDown;

  // Per-sample increment: full scale over ramp length in samples
  always @* begin
    samplesUp = upTime * SAMPLES_PER_TENTH;
    samplesDown = downTime * SAMPLES_PER_TENTH;
    quotUp = (samplesUp == 32'h0) ? 32'h0 : fullScale / samplesUp;
    quotDown = (samplesDown == 32'h0) ? 32'h0 : fullScale / samplesDown;
    // Never a zero step, or the ramp would stall short of its target
    stepUp = (samplesUp == 32'h0) ? {W{1'b1}} :
      (quotUp == 32'h0) ? {{(W-1){1'b0}}, 1'b1} : quotUp[W-1:0];
    stepDown = (samplesDown == 32'h0) ? {W{1'b1}} :
      (quotDown == 32'h0) ? {{(W-1){1'b0}}, 1'b1} :
      quotDown[W-1:0];
    if (value < target)
      next_value = (target - value > stepUp) ? value + stepUp : target;
    else if (value > target)
      next_value = (value - target > stepDown) ? value - stepDown : target;
    else
      next_value = value;
  end

  // Step once per sample
  always @(posedge clk) begin
    if (rst) begin
      value <= {W{1'b0}};
      atTarget <= 1'b1;
    end else if (tick) begin
      value <= next_value;
      atTarget <= (next_value == target);
    end
  end
endmodule // ramp_unit

// file: verif/vf_sep_stall_chk.sv
// Port checker of the V/F separation and stall control top.
// Assumes sync active-high rst and the register map of the defines header.
`timescale 1ns/100ps
`include "vf_sep_defines.vh"
module vf_sep_stall_chk #(
  parameter SAMPLE_CYCLES = 1000000,
  parameter RATED_VOLT = 16'h0DAC,
  parameter RATED_FREQ = 16'h1388
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] outVoltage,
  input wire [15:0] outFreq,
  input wire ocStallActive,
  input wire ovStallActive,
  input wire stopped
);
  wire wrDone = psel && penable && pready && pwrite;
  reg ocOff;
  reg ovOn;
  reg modeSeq;
  reg stopPend;
  // Shadow of switches, shutdown mode and stop request from APB writes
  always @(posedge clk) begin
    if (rst) begin
      ocOff <= 1'b1;
      ovOn <= 1'b1;
      modeSeq <= 1'b0;
      stopPend <= 1'b0;
    end else if (wrDone) begin
      if (paddr == `ADDR_OC_SWITCH && pwdata[31:1] == 31'h0)
        ocOff <= pwdata[0];
      if (paddr == `ADDR_OV_SWITCH && pwdata[31:1] == 31'h0)
        ovOn <= pwdata[0];
      if (paddr == `ADDR_SHUTDOWN_MODE && pwdata[31:1] == 31'h0)
        modeSeq <= pwdata[0];
      if (paddr == `ADDR_CONTROL && pwdata[1])
        stopPend <= 1'b1;
      else if (paddr == `ADDR_CONTROL && pwdata[0])
        stopPend <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Bus handshake and outputs after reset
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready in access cycle");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  reset_state_a: assert property ($fell(rst) |-> stopped && !ocStallActive
    && outVoltage == 16'h0000 && outFreq == 16'h0000)
    else $error("outputs not cleared by reset");
  // Stall functions and shutdown order
  oc_switch_off_a: assert property ($rose(ocStallActive) |-> !$past(ocOff))
    else $error("current stall while switched off");
  ov_switch_off_a: assert property ($rose(ovStallActive) |-> $past(ovOn))
    else $error("voltage stall while switched off");
  oc_lowers_freq_a: assert property (ocStallActive && $changed(outFreq)
    |-> outFreq < $past(outFreq)) else $error("frequency rose in stall");
  seq_stop_a: assert property (stopPend && modeSeq && outVoltage != 16'h0000
    ##1 outVoltage != 16'h0000 |-> outFreq >= $past(outFreq))
    else $error("frequency fell before voltage");
  stopped_zero_a: assert property ($rose(stopped)
    |-> outVoltage == 16'h0000 && outFreq == 16'h0000)
    else $error("stopped with output live");

  cover property (ocStallActive);
  cover property (ovStallActive);
  cover property (stopPend && $rose(stopped));
endmodule // vf_sep_stall_chk

bind vf_sep_stall_ctrl vf_sep_stall_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
  .RATED_VOLT(RATED_VOLT), .RATED_FREQ(RATED_FREQ)) chk (.clk(clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .outVoltage(outVoltage), .outFreq(outFreq),
  .ocStallActive(ocStallActive), .ovStallActive(ovStallActive),
  .stopped(stopped));

// file: verif/motor_stage_model.sv
// Far-side model: power stage and motor giving current and DC bus voltage.
// Assumes outFreq moves once per sample; load and regen set by the bench.
`timescale 1ns/100ps
module motor_stage_model (
  input wire clk,
  input wire rst,
  input wire [15:0] outFreq,
  input wire [15:0] loadLevel,
  input wire [15:0] regenLevel,
  output wire [15:0] outputCurrent,
  output reg [15:0] busVoltage
);
  reg [15:0] lastFreq;
  // A motor at standstill draws nothing; running, it draws the load
  assign outputCurrent = (outFreq == 16'h0000) ? 16'h0000 : loadLevel;
  // A falling frequency regenerates and lifts the bus until the next step
  always @(posedge clk) begin
    if (rst) begin
      lastFreq <= 16'h0000;
      busVoltage <= 16'h1518;
    end else if (outFreq != lastFreq) begin
      lastFreq <= outFreq;
      busVoltage <= (outFreq < lastFreq) ? regenLevel : 16'h1518;
    end
  end
endmodule // motor_stage_model

// file: verif/vf_sep_stall_ctrl_tb.sv
// Self-checking bench of the V/F separation and stall control block.
// Assumes APB register access and the motor stage model on the far side.
`timescale 1ns/100ps
`include "vf_sep_defines.vh"
module vf_sep_stall_ctrl_tb;
  localparam SC = 10;
  localparam [15:0] RV = 16'h0DAC;
  localparam [15:0] FT = 16'h0FA0;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, ocStallActive, ovStallActive, stopped;
  logic [15:0] src [0:5] = '{default: 16'h0000};
  logic [15:0] targetFreq = FT, loadLevel = 16'h0000, regenLevel = 16'h1518;
  logic [15:0] outputCurrent, busVoltage, outVoltage, outFreq, d, e;
  logic [3:0] codes [0:6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8};
  integer err_count = 0, checks = 0, seed = 22327, i, n;

  always #5 clk = ~clk;

  vf_sep_stall_ctrl #(.SAMPLE_CYCLES(SC), .RATED_VOLT(RV),
    .RATED_FREQ(16'h1388)) dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogInputOne(src[0]), .analogInputTwo(src[1]),
    .analogInputThree(src[2]), .sequencerValue(src[3]), .pidValue(src[4]),
    .hostValue(src[5]), .targetFreq(targetFreq),
    .outputCurrent(outputCurrent), .busVoltage(busVoltage),
    .outVoltage(outVoltage), .outFreq(outFreq),
    .ocStallActive(ocStallActive), .ovStallActive(ovStallActive),
    .stopped(stopped));

  motor_stage_model stage (.clk(clk), .rst(rst), .outFreq(outFreq),
    .loadLevel(loadLevel), .regenLevel(regenLevel),
    .outputCurrent(outputCurrent), .busVoltage(busVoltage));

  // Comparisons: exact, and within a range where rounding may differ
  task cmp(input string nm, input logic [31:0] ex, input logic [31:0] g);
    checks = checks + 1;
    if (g !== ex) begin
      err_count = err_count + 1;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task cmpin(input string nm, input logic [31:0] lo, hi, g);
    checks = checks + 1;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count = err_count + 1;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    cmp(nm, ex, rdata);
  endtask
  task ticks(input integer k);
    repeat (k * SC) @(posedge clk);
  endtask
  // Wait until voltage and frequency sit at their settings
  task settle;
    for (n = 0; n < 6000 && (outVoltage !== RV || outFreq !== targetFreq);
      n++) @(posedge clk);
  endtask
  // Time a voltage ramp in samples
  task ramp(input logic [15:0] tgt, input integer k);
    apb(1'b1, `ADDR_DIGITAL_VOLT, {16'h0, tgt});
    for (n = 0; n < 40 * SC && outVoltage !== tgt; n++) @(posedge clk);
    cmpin("rampSamples", k - 1, k + 1, n / SC);
  endtask
  // Expected voltage: digital setting direct, others scaled magnitudes
  function automatic logic [15:0] expv(input logic [3:0] c,
    input logic [15:0] dv);
    logic [15:0] x;
    logic [31:0] p;
    if (c == 4'h0) return dv;
    x = src[c > 4'h3 ? c - 4'h3 : c - 4'h1];
    if (x[15]) x = -x;
    p = x * RV / 1000;
    return p[15:0];
  endfunction

  task finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cut a hung run short
  initial begin
    #500000;
    err_count = err_count + 1;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("ocThr", `ADDR_OC_THRESHOLD, 32'h00000096);
    rdchk("ocSw", `ADDR_OC_SWITCH, 32'h00000001);
    rdchk("ocGain", `ADDR_OC_GAIN, 32'h00000014);
    rdchk("hsFactor", `ADDR_HS_FACTOR, 32'h00000032);
    rdchk("ovSw", `ADDR_OV_SWITCH, 32'h00000001);
    rdchk("ovFGain", `ADDR_OV_FREQ_GAIN, 32'h00000064);
    rdchk("ovVGain", `ADDR_OV_VOLT_GAIN, 32'h0000001E);
    rdchk("ovMax", `ADDR_OV_MAX_RISE, 32'h000001F4);
    rdchk("riseT", `ADDR_RISE_TIME, 32'h00000000);
    apb(1'b0, 12'h080, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, rerr});
    // Every source code with random levels of both signs, step ramps
    apb(1'b1, `ADDR_CONTROL, 32'h1);
    for (i = 0; i < 7; i++) begin
      for (n = 0; n < 6; n++) src[n] <= 16'($random(seed) % 1001);
      d = 16'($unsigned($random(seed)) % 10001);
      apb(1'b1, `ADDR_VOLT_SOURCE, {28'h0, codes[i]});
      apb(1'b1, `ADDR_DIGITAL_VOLT, {16'h0, d});
      ticks(3);
      e = expv(codes[i], d);
      cmpin("srcVolt", e - (e != 16'h0), e + 1, outVoltage);
    end
    // Ramp timing: 0.1 s is ten samples up, 0.2 s twenty down
    apb(1'b1, `ADDR_VOLT_SOURCE, 32'h0);
    apb(1'b1, `ADDR_DIGITAL_VOLT, 32'h0);
    ticks(2);
    apb(1'b1, `ADDR_RISE_TIME, 32'h1);
    apb(1'b1, `ADDR_DROP_TIME, 32'h2);
    ramp(RV, 10);
    ramp(16'h0000, 20);
    // Sequenced shutdown: frequency held until the voltage is gone
    apb(1'b1, `ADDR_DIGITAL_VOLT, {16'h0, RV});
    apb(1'b1, `ADDR_DECEL_TIME, 32'h1);
    apb(1'b1, `ADDR_SHUTDOWN_MODE, 32'h1);
    settle;
    apb(1'b1, `ADDR_CONTROL, 32'h2);
    for (n = 0; n < 900 && outVoltage !== 16'h0; n++) @(posedge clk);
    cmp("freqAtZeroV", {16'h0, FT}, {16'h0, outFreq});
    for (n = 0; n < 900 && stopped !== 1'b1; n++) @(posedge clk);
    cmp("freqStop", 32'h0, {16'h0, outFreq});
    // Independent shutdown: both quantities fall together
    apb(1'b1, `ADDR_SHUTDOWN_MODE, 32'h0);
    apb(1'b1, `ADDR_CONTROL, 32'h1);
    settle;
    apb(1'b1, `ADDR_CONTROL, 32'h2);
    ticks(5);
    cmpin("freqFall", 0, FT - 1, outFreq);
    cmpin("voltFall", 1, RV - 1, outVoltage);
    // Voltage is at zero once the drive has stopped
    for (n = 0; n < 900 && stopped !== 1'b1; n++) @(posedge clk);
    cmp("voltStop", 32'h0, {16'h0, outVoltage});
    // Current stall: off by default, then limiting at 100 percent
    apb(1'b1, `ADDR_CONTROL, 32'h1);
    settle;
    apb(1'b1, `ADDR_OC_THRESHOLD, 32'h000000C9);
    rdchk("thrRange", `ADDR_OC_THRESHOLD, 32'h00000096);
    apb(1'b1, `ADDR_OC_THRESHOLD, 32'h00000064);
    loadLevel <= 16'h04B0;
    ticks(10);
    cmp("ocIdle", 32'h0, {31'h0, ocStallActive});
    apb(1'b1, `ADDR_OC_SWITCH, 32'h0);
    for (n = 0; n < 20 * SC && ocStallActive !== 1'b1; n++) @(posedge clk);
    cmp("ocOn", 32'h1, {31'h0, ocStallActive});
    ticks(1);
    cmpin("freqCut", 0, FT - 1, outFreq);
    loadLevel <= 16'h03DE;
    settle;
    cmp("freqBack", {16'h0, FT}, {16'h0, outFreq});
    cmp("ocBelow", 32'h0, {31'h0, ocStallActive});
    // Voltage stall on regeneration, then a braking unit fitted
    apb(1'b1, `ADDR_OC_SWITCH, 32'h1);
    apb(1'b1, `ADDR_OV_POINT, 32'h00001770);
    regenLevel <= 16'h1B58;
    targetFreq <= 16'h07D0;
    for (n = 0; n < 20 * SC && ovStallActive !== 1'b1; n++) @(posedge clk);
    cmp("ovOn", 32'h1, {31'h0, ovStallActive});
    apb(1'b1, `ADDR_OVEREXC_GAIN, 32'h0);
    apb(1'b1, `ADDR_OV_SWITCH, 32'h0);
    targetFreq <= FT;
    settle;
    targetFreq <= 16'h07D0;
    ticks(20);
    cmp("ovOff", 32'h0, {31'h0, ovStallActive});
    cmp("decelDone", 32'h000007D0, {16'h0, outFreq});
    finish_test;
  end
endmodule // vf_sep_stall_ctrl_tb
